/* File: logic/interval_timer.sv */
// Millisecond interval timer that emits one step pulse per elapsed interval
`timescale 1ns/10ps
`default_nettype none
module interval_timer
   import msg_text_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Time base and control
   input wire logic ms_tick_i,
   input wire logic restart_i,
   input wire logic [msg_text_pkg::LEN_W-1:0] len_i,
   // Step pulse
   output logic step_o
);
   logic [LEN_W-1:0] count_q;
   logic [LEN_W-1:0] count_d;
   logic done;
   logic step_q;

   // A zero length still steps once per tick, never faster
   assign done = ms_tick_i && ((count_q + 20'h00001) >= len_i);
   assign count_d = restart_i ? COUNT_RESET :
                    done ? COUNT_RESET :
                    ms_tick_i ? count_q + 20'h00001 : count_q;

   // Counter and registered step pulse
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= COUNT_RESET;
         step_q <= 1'b0;
      end else begin
         count_q <= count_d;
         step_q <= done && !restart_i;
      end
   end

   assign step_o = step_q;
endmodule
`default_nettype wire

/* File: logic/msg_text_pkg.sv */
// Shared constants and types for the message text selection block
package msg_text_pkg;
   // Message slot count and field widths
   localparam int NUM_MSG = 50;
   localparam int IDX_W = 6;
   localparam int PRIO_W = 7;
   localparam int DEST_W = 2;
   localparam int STAMP_W = 16;
   localparam int MS_W = 16;
   localparam int LEN_W = 20;
   localparam int POS_W = 5;

   // Priority limits, zero is lowest
   localparam logic [PRIO_W-1:0] PRIO_MIN = 7'h00;
   localparam logic [PRIO_W-1:0] PRIO_MAX = 7'h7f;

   // Destination encodings, code 3 falls back to the base unit
   localparam logic [DEST_W-1:0] DEST_BASE = 2'h0;
   localparam logic [DEST_W-1:0] DEST_EXT = 2'h1;
   localparam logic [DEST_W-1:0] DEST_BOTH = 2'h2;

   // Scroll geometry of one display line
   localparam logic [POS_W-1:0] LINE_CHARS = 5'h18;
   localparam logic [POS_W-1:0] HALF_CHARS = 5'h0c;
   localparam logic [POS_W-1:0] POS_RESET = 5'h00;
   localparam logic [LEN_W-1:0] LINE_STEP_MULT = 20'h0000a;

   // Time base: one millisecond at a 4 ns clock
   localparam int MS_PERIOD_NS = 1000000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CYCLES_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 18;

   // Reset values
   localparam logic [IDX_W-1:0] IDX_RESET = 6'h00;
   localparam logic [STAMP_W-1:0] STAMP_RESET = 16'h0000;
   localparam logic [LEN_W-1:0] COUNT_RESET = 20'h00000;
endpackage

/* File: logic/msg_text_select.sv */
// Message text slots, priority selection, acknowledgement and scrolling
`timescale 1ns/10ps
`default_nettype none
module msg_text_select
   import msg_text_pkg::*;
#(
   // Clock cycles per millisecond, shorten for simulation
   parameter int MS_CYCLES = msg_text_pkg::CYCLES_PER_MS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Relay mode and program flag
   input wire logic run_mode_i,
   input wire logic charset_select_flag_i,
   // Per-slot trigger inputs
   input wire logic [msg_text_pkg::NUM_MSG-1:0] trigger_i,
   // Per-slot configuration
   input wire logic [msg_text_pkg::NUM_MSG*msg_text_pkg::PRIO_W-1:0] priority_i,
   input wire logic [msg_text_pkg::NUM_MSG-1:0] ack_en_i,
   input wire logic [msg_text_pkg::NUM_MSG*msg_text_pkg::DEST_W-1:0] dest_i,
   input wire logic [msg_text_pkg::NUM_MSG-1:0] secondary_glyph_table_i,
   input wire logic [msg_text_pkg::NUM_MSG-1:0] scroll_en_i,
   input wire logic [msg_text_pkg::NUM_MSG-1:0] scroll_by_line_i,
   // Global intervals in milliseconds
   input wire logic [msg_text_pkg::MS_W-1:0] scroll_interval_i,
   input wire logic [msg_text_pkg::MS_W-1:0] analog_interval_i,
   // Clock and calendar values
   input wire logic [msg_text_pkg::STAMP_W-1:0] time_of_day_i,
   input wire logic [msg_text_pkg::STAMP_W-1:0] calendar_date_i,
   // Operator keys, one-cycle pulses
   input wire logic confirm_key_i,
   input wire logic key_up_i,
   input wire logic key_down_i,
   // Per-slot active outputs
   output logic [msg_text_pkg::NUM_MSG-1:0] active_o,
   // Presented message
   output logic shown_valid_o,
   output logic [msg_text_pkg::IDX_W-1:0] shown_index_o,
   output logic base_unit_display_o,
   output logic external_text_display_o,
   output logic [msg_text_pkg::POS_W-1:0] scroll_pos_o,
   output logic [msg_text_pkg::STAMP_W-1:0] trigger_time_stamp_o,
   output logic [msg_text_pkg::STAMP_W-1:0] trigger_date_stamp_o,
   // Analog value refresh strobe
   output logic analog_refresh_o
);
   // Slot state
   logic [NUM_MSG-1:0] trig_q; // Trigger seen last cycle
   logic [NUM_MSG-1:0] set_q; // Message set, also the active output
   logic [NUM_MSG-1:0] set_d;
   logic [NUM_MSG-1:0] rise; // Rising edge in run mode
   logic [NUM_MSG-1:0] elig; // May be presented now
   logic [NUM_MSG-1:0] cand; // Competes for selection this cycle

   // Presentation state
   logic shown_ok_q;
   logic shown_ok_d;
   logic [IDX_W-1:0] shown_idx_q;
   logic [IDX_W-1:0] shown_idx_d;
   logic base_q;
   logic ext_q;
   logic [POS_W-1:0] pos_q;
   logic [POS_W-1:0] pos_d;
   logic [STAMP_W-1:0] tstamp_q;
   logic [STAMP_W-1:0] dstamp_q;

   // Stamp memories, one entry per slot; data only, no reset needed
   logic [STAMP_W-1:0] time_mem [NUM_MSG];
   logic [STAMP_W-1:0] date_mem [NUM_MSG];

   // Millisecond prescaler
   logic [PRESC_W-1:0] presc_q;
   logic ms_tick;

   // Selection results
   logic best_ok;
   logic [IDX_W-1:0] best_idx;
   logic [PRIO_W-1:0] best_prio;
   logic old_ok;
   logic [PRIO_W-1:0] old_prio;
   logic rise_ok;
   logic [IDX_W-1:0] rise_idx;
   logic [PRIO_W-1:0] rise_prio;
   logic up_hi_ok;
   logic up_lo_ok;
   logic dn_lo_ok;
   logic dn_hi_ok;
   logic [IDX_W-1:0] up_hi;
   logic [IDX_W-1:0] up_lo;
   logic [IDX_W-1:0] dn_lo;
   logic [IDX_W-1:0] dn_hi;

   // Decoded fields of the current and next presented slot
   logic [PRIO_W-1:0] shown_prio;
   logic shown_elig;
   logic [DEST_W-1:0] next_dest;
   logic changed;
   logic next_scroll;
   logic next_line;
   logic [LEN_W-1:0] scroll_len;
   logic [LEN_W-1:0] analog_len;
   logic scroll_step;
   logic ack_hit;

   // Slot-level decode; the charset flag picks which table may show
   assign rise = trigger_i & ~trig_q & {NUM_MSG{run_mode_i}};
   assign elig = set_q & {NUM_MSG{run_mode_i}} &
                 (charset_select_flag_i ? secondary_glyph_table_i
                                        : ~secondary_glyph_table_i);
   // A fresh rise competes in the cycle it is taken; were it to wait for its set
   // flag, it would count as old and a higher newcomer could never take over
   assign cand = elig |
                 (rise & ~(secondary_glyph_table_i ^ {NUM_MSG{charset_select_flag_i}}));

   // Confirm acts only on the presented slot with its trigger low
   assign ack_hit = confirm_key_i && shown_ok_q && !trigger_i[shown_idx_q];

   // Next set state per slot; a rise wins over any clear in the same cycle
   always_comb begin
      for (int i = 0; i < NUM_MSG; i++) begin
         if (rise[i]) begin
            set_d[i] = 1'b1;
         end else if (set_q[i] && !trigger_i[i] && !ack_en_i[i]) begin
            set_d[i] = 1'b0;
         end else if (set_q[i] && ack_en_i[i] && ack_hit &&
                      (shown_idx_q == IDX_W'(i))) begin
            set_d[i] = 1'b0;
         end else begin
            set_d[i] = set_q[i];
         end
      end
   end

   // Priority search; ties go to the lower slot number
   always_comb begin
      best_ok = 1'b0;
      best_idx = IDX_RESET;
      best_prio = PRIO_MIN;
      old_ok = 1'b0;
      old_prio = PRIO_MIN;
      rise_ok = 1'b0;
      rise_idx = IDX_RESET;
      rise_prio = PRIO_MIN;
      up_hi_ok = 1'b0;
      up_lo_ok = 1'b0;
      dn_lo_ok = 1'b0;
      dn_hi_ok = 1'b0;
      up_hi = IDX_RESET;
      up_lo = IDX_RESET;
      dn_lo = IDX_RESET;
      dn_hi = IDX_RESET;
      for (int i = 0; i < NUM_MSG; i++) begin
         if (cand[i]) begin
            // Greatest priority overall, 127 highest
            if (!best_ok || priority_i[i*PRIO_W +: PRIO_W] > best_prio) begin
               best_ok = 1'b1;
               best_idx = IDX_W'(i);
               best_prio = priority_i[i*PRIO_W +: PRIO_W];
            end
            // Messages that were already active before this cycle
            if (!rise_q_free(rise[i]) &&
                (!old_ok || priority_i[i*PRIO_W +: PRIO_W] > old_prio)) begin
               old_ok = 1'b1;
               old_prio = priority_i[i*PRIO_W +: PRIO_W];
            end
            // Newly triggered messages
            if (rise[i] &&
                (!rise_ok || priority_i[i*PRIO_W +: PRIO_W] > rise_prio)) begin
               rise_ok = 1'b1;
               rise_idx = IDX_W'(i);
               rise_prio = priority_i[i*PRIO_W +: PRIO_W];
            end
            // Neighbours for key stepping, with wrap-around
            if (!up_hi_ok && IDX_W'(i) > shown_idx_q) begin
               up_hi_ok = 1'b1;
               up_hi = IDX_W'(i);
            end
            if (!up_lo_ok) begin
               up_lo_ok = 1'b1;
               up_lo = IDX_W'(i);
            end
            if (IDX_W'(i) < shown_idx_q) begin
               dn_lo_ok = 1'b1;
               dn_lo = IDX_W'(i);
            end
            dn_hi_ok = 1'b1;
            dn_hi = IDX_W'(i);
         end
      end
   end

   // Trivial helper keeps the older-message filter readable
   function automatic logic rise_q_free(input logic r);
      return r;
   endfunction

   // Facts about the slot presented now
   assign shown_prio = priority_i[shown_idx_q*PRIO_W +: PRIO_W];
   assign shown_elig = shown_ok_q && elig[shown_idx_q];

   // Choice of the next presented slot
   always_comb begin
      shown_ok_d = best_ok;
      shown_idx_d = shown_idx_q;
      if (!best_ok) begin
         shown_idx_d = shown_idx_q;
      end else if (!shown_elig) begin
         shown_idx_d = best_idx;
      end else if (rise_ok && rise_prio > shown_prio &&
                   (!old_ok || rise_prio > old_prio)) begin
         shown_idx_d = rise_idx;
      end else if (key_up_i) begin
         shown_idx_d = up_hi_ok ? up_hi : up_lo;
      end else if (key_down_i) begin
         shown_idx_d = dn_lo_ok ? dn_lo : dn_hi;
      end
   end

   // Routing and scroll settings of the next slot
   assign next_dest = dest_i[shown_idx_d*DEST_W +: DEST_W];
   assign changed = (shown_idx_d != shown_idx_q) || (shown_ok_d != shown_ok_q);
   assign next_scroll = scroll_en_i[shown_idx_d];
   assign next_line = scroll_by_line_i[shown_idx_d];

   // Line mode waits ten intervals, character mode one
   assign scroll_len = next_line ? LEN_W'(scroll_interval_i) * LINE_STEP_MULT
                                 : LEN_W'(scroll_interval_i);
   assign analog_len = LEN_W'(analog_interval_i);

   // Scroll position: characters rotate, halves alternate
   always_comb begin
      pos_d = pos_q;
      if (changed || !shown_ok_d || !next_scroll) begin
         pos_d = POS_RESET;
      end else if (scroll_step) begin
         if (next_line) begin
            pos_d = (pos_q == POS_RESET) ? HALF_CHARS : POS_RESET;
         end else begin
            pos_d = (pos_q + 5'h01 >= LINE_CHARS) ? POS_RESET : pos_q + 5'h01;
         end
      end
   end

   // Millisecond time base shared by both interval timers
   assign ms_tick = (presc_q == PRESC_W'(MS_CYCLES - 1));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         presc_q <= '0;
      end else begin
         presc_q <= ms_tick ? '0 : presc_q + 18'h00001;
      end
   end

   // Slot trigger history and set flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_q <= '0;
         set_q <= '0;
      end else begin
         trig_q <= trigger_i;
         set_q <= set_d;
      end
   end

   // Stamp capture at the rising edge of each trigger
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NUM_MSG; i++) begin
         if (rise[i]) begin
            time_mem[i] <= time_of_day_i;
            date_mem[i] <= calendar_date_i;
         end
      end
   end

   // Presented slot and its routing, all registered
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shown_ok_q <= 1'b0;
         shown_idx_q <= IDX_RESET;
         base_q <= 1'b0;
         ext_q <= 1'b0;
         pos_q <= POS_RESET;
      end else begin
         shown_ok_q <= shown_ok_d;
         shown_idx_q <= shown_idx_d;
         base_q <= shown_ok_d && (next_dest != DEST_EXT);
         ext_q <= shown_ok_d && (next_dest == DEST_EXT || next_dest == DEST_BOTH);
         pos_q <= pos_d;
      end
   end

   // Stamp readout; memory holds no reset so the stamps gate on valid, and a
   // slot rising now is not in memory yet, so its stamp bypasses the array
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tstamp_q <= STAMP_RESET;
         dstamp_q <= STAMP_RESET;
      end else begin
         tstamp_q <= !shown_ok_d ? STAMP_RESET :
                     rise[shown_idx_d] ? time_of_day_i : time_mem[shown_idx_d];
         dstamp_q <= !shown_ok_d ? STAMP_RESET :
                     rise[shown_idx_d] ? calendar_date_i : date_mem[shown_idx_d];
      end
   end

   // Scroll step timer restarts whenever the presented slot changes
   interval_timer scroll_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ms_tick_i(ms_tick),
      .restart_i(changed),
      .len_i(scroll_len),
      .step_o(scroll_step)
   );

   // Analog refresh runs freely in run mode; outside run mode it is held restarted and gives no pulses
   interval_timer analog_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ms_tick_i(ms_tick),
      .restart_i(!run_mode_i),
      .len_i(analog_len),
      .step_o(analog_refresh_o)
   );

   // Outputs straight from flip-flops
   assign active_o = set_q;
   assign shown_valid_o = shown_ok_q;
   assign shown_index_o = shown_idx_q;
   assign base_unit_display_o = base_q;
   assign external_text_display_o = ext_q;
   assign scroll_pos_o = pos_q;
   assign trigger_time_stamp_o = tstamp_q;
   assign trigger_date_stamp_o = dstamp_q;
endmodule
`default_nettype wire

/* File: tb/msg_text_checker.sv */
// Port-level checks on the message selector
`timescale 1ns/10ps
`default_nettype none
module msg_text_checker
   import msg_text_pkg::*;
#(
   parameter int MS_CYCLES = 4
) (
   // Clock, reset, mode
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_mode_i,
   input wire logic charset_select_flag_i,
   // Slot inputs
   input wire logic [NUM_MSG-1:0] trigger_i,
   input wire logic [NUM_MSG-1:0] ack_en_i,
   input wire logic [NUM_MSG-1:0] secondary_glyph_table_i,
   // Selector outputs
   input wire logic [NUM_MSG-1:0] active_o,
   input wire logic shown_valid_o,
   input wire logic [IDX_W-1:0] shown_index_o,
   input wire logic base_unit_display_o,
   input wire logic external_text_display_o,
   input wire logic [POS_W-1:0] scroll_pos_o,
   input wire logic [STAMP_W-1:0] trigger_time_stamp_o,
   input wire logic [STAMP_W-1:0] trigger_date_stamp_o,
   input wire logic analog_refresh_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Trigger history, previous set state, cycles since refresh
   logic [NUM_MSG-1:0] trig_q, trig_q2, act_q;
   int gap_q;
   // Only rises seen in run mode count
   wire logic [NUM_MSG-1:0] rise = trigger_i & ~trig_q & {NUM_MSG{run_mode_i}};
   // History kept beside the design, cleared with it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_q <= '0;
         trig_q2 <= '0;
         act_q <= '0;
         gap_q <= 0;
      end else begin
         trig_q <= trigger_i;
         trig_q2 <= trig_q;
         act_q <= active_o;
         gap_q <= analog_refresh_o ? 0 : gap_q + 1;
      end
   end
   a_rise_sets: assert property (|rise |=> ($past(rise) & ~active_o) == '0)
      else $error("slot not set after rise");
   a_ack_off_clear: assert property ((active_o & ~ack_en_i & ~trigger_i & ~trig_q & ~trig_q2) == '0)
      else $error("slot kept after trigger fell");
   a_held_high: assert property ((act_q & trig_q & trig_q2 & ~active_o) == '0)
      else $error("slot dropped while trigger high");
   a_run_gate: assert property (!run_mode_i |=> !shown_valid_o)
      else $error("message shown outside run mode");
   a_idle_dark: assert property (!shown_valid_o |->
      !base_unit_display_o && !external_text_display_o
      && trigger_time_stamp_o == '0 && trigger_date_stamp_o == '0)
      else $error("idle view not dark");
   a_route_any: assert property (shown_valid_o |->
      base_unit_display_o || external_text_display_o)
      else $error("shown message has no display");
   a_shown_set: assert property (shown_valid_o |->
      act_q[shown_index_o] || active_o[shown_index_o])
      else $error("shown slot is not set");
   a_glyph_match: assert property (shown_valid_o && $stable(charset_select_flag_i) |->
      secondary_glyph_table_i[shown_index_o] == charset_select_flag_i)
      else $error("shown slot from wrong glyph table");
   a_scroll_bound: assert property (shown_valid_o |-> scroll_pos_o < LINE_CHARS)
      else $error("scroll position past line end");
   a_refresh_gap: assert property (analog_refresh_o |-> gap_q >= MS_CYCLES - 1)
      else $error("analog refresh too soon");
   // Main scenarios reached
   c_ack_wait: cover property (|(active_o & ack_en_i & ~trigger_i));
   c_line_half: cover property (scroll_pos_o == HALF_CHARS);
   c_second_table: cover property (shown_valid_o && charset_select_flag_i);
endmodule
bind msg_text_select msg_text_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);
`default_nettype wire

/* File: tb/msg_text_select_tb.sv */
// Self-checking bench for the message selector
`timescale 1ns/10ps
`default_nettype none
module msg_text_select_tb;
   import msg_text_pkg::*;
   // Short millisecond keeps scroll and refresh runs brief
   localparam int MSC = 4;
   // Clock, reset, mode
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic run_mode_i = 1'b1;
   logic charset_select_flag_i = 1'b0;
   // Slot inputs
   logic [NUM_MSG-1:0] trigger_i = '0;
   logic [NUM_MSG*PRIO_W-1:0] priority_i = '0;
   logic [NUM_MSG-1:0] ack_en_i = '0;
   logic [NUM_MSG*DEST_W-1:0] dest_i = '0;
   logic [NUM_MSG-1:0] secondary_glyph_table_i = '0;
   logic [NUM_MSG-1:0] scroll_en_i = '0;
   logic [NUM_MSG-1:0] scroll_by_line_i = '0;
   // Intervals in ms and stamp sources
   logic [MS_W-1:0] scroll_interval_i = 16'h0001;
   logic [MS_W-1:0] analog_interval_i = 16'h0002;
   logic [STAMP_W-1:0] time_of_day_i = 16'h1234;
   logic [STAMP_W-1:0] calendar_date_i = 16'h5678;
   // Keys and outputs
   logic confirm_key_i, key_up_i, key_down_i;
   logic [NUM_MSG-1:0] active_o;
   logic shown_valid_o, base_unit_display_o, external_text_display_o, analog_refresh_o;
   logic [IDX_W-1:0] shown_index_o;
   logic [POS_W-1:0] scroll_pos_o;
   logic [STAMP_W-1:0] trigger_time_stamp_o, trigger_date_stamp_o;
   int err_total = 0;
   int n_tests = 0;
   int k;
   always #2 clk_i = ~clk_i;
   msg_text_select #(.MS_CYCLES(MSC)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .run_mode_i(run_mode_i),
      .charset_select_flag_i(charset_select_flag_i), .trigger_i(trigger_i),
      .priority_i(priority_i), .ack_en_i(ack_en_i), .dest_i(dest_i),
      .secondary_glyph_table_i(secondary_glyph_table_i), .scroll_en_i(scroll_en_i),
      .scroll_by_line_i(scroll_by_line_i), .scroll_interval_i(scroll_interval_i),
      .analog_interval_i(analog_interval_i), .time_of_day_i(time_of_day_i),
      .calendar_date_i(calendar_date_i), .confirm_key_i(confirm_key_i),
      .key_up_i(key_up_i), .key_down_i(key_down_i), .active_o(active_o),
      .shown_valid_o(shown_valid_o), .shown_index_o(shown_index_o),
      .base_unit_display_o(base_unit_display_o),
      .external_text_display_o(external_text_display_o), .scroll_pos_o(scroll_pos_o),
      .trigger_time_stamp_o(trigger_time_stamp_o),
      .trigger_date_stamp_o(trigger_date_stamp_o), .analog_refresh_o(analog_refresh_o)
   );
   op_panel_model pnl (.clk_i(clk_i), .confirm_key_o(confirm_key_i), .key_up_o(key_up_i),
      .key_down_o(key_down_i));
   // Compare, count, report a miss at once
   task automatic chk(input string n, input logic [19:0] g, input logic [19:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Let n edges pass, then step off the edge
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Move one trigger; four edges cover set, clear and reselection
   task automatic fire(input int s, input logic v);
      @(posedge clk_i);
      trigger_i[s] <= v;
      tk(4);
   endtask
   // Presented validity and slot
   task automatic see(input logic v, input logic [IDX_W-1:0] i);
      chk("shown_valid", shown_valid_o, v);
      if (v) begin
         chk("shown_index", shown_index_o, i);
      end
   endtask
   task automatic cfg(input int s, input logic [PRIO_W-1:0] p, input logic [DEST_W-1:0] d);
      priority_i[s*PRIO_W+:PRIO_W] <= p;
      dest_i[s*DEST_W+:DEST_W] <= d;
   endtask
   // Bounded waits; running out ends the run
   task automatic wait_pos(input logic [POS_W-1:0] v, input int lim);
      int j;
      for (j = 0; j < lim && scroll_pos_o !== v; j++) begin
         tk(1);
      end
      chk("scroll_pos", scroll_pos_o, v);
      if (j == lim) final_report();
   endtask
   task automatic wait_pulse(output int n);
      for (n = 1; n < 40 && analog_refresh_o !== 1'b1; n++) begin
         tk(1);
      end
      if (n == 40) begin
         err_total++;
         final_report();
      end
   endtask
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      cfg(3, 7'h05, DEST_EXT);
      cfg(10, 7'h14, DEST_BOTH);
      cfg(11, 7'h0a, DEST_BASE);
      cfg(12, PRIO_MAX, 2'h3);
      cfg(5, 7'h1e, DEST_BASE);
      cfg(7, 7'h28, DEST_BASE);
      ack_en_i[5] <= 1'b1;
      secondary_glyph_table_i[7] <= 1'b1;
      scroll_en_i[21:20] <= 2'h3;
      scroll_by_line_i[21] <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      tk(1);
      see(1'b0, 0);
      // Single message: set, route, stamps, clear without ack
      fire(3, 1'b1);
      see(1'b1, 3);
      chk("routing", {base_unit_display_o, external_text_display_o}, 2'h1);
      chk("time_stamp", trigger_time_stamp_o, 16'h1234);
      chk("date_stamp", trigger_date_stamp_o, 16'h5678);
      @(posedge clk_i);
      time_of_day_i <= 16'h4321;
      tk(2);
      chk("time_kept", trigger_time_stamp_o, 16'h1234);
      fire(3, 1'b0);
      chk("active3", active_o[3], 1'b0);
      see(1'b0, 0);
      // Priority: lower never replaces, top value wins, fallback on clear
      fire(10, 1'b1);
      chk("routing", {base_unit_display_o, external_text_display_o}, 2'h3);
      fire(11, 1'b1);
      see(1'b1, 10);
      fire(12, 1'b1);
      see(1'b1, 12);
      chk("code3_base", {base_unit_display_o, external_text_display_o}, 2'h2);
      fire(12, 1'b0);
      see(1'b1, 10);
      fire(10, 1'b0);
      see(1'b1, 11);
      fire(11, 1'b0);
      fire(49, 1'b1);
      see(1'b1, 49);
      fire(49, 1'b0);
      // Acknowledged message outlives its trigger until confirm
      fire(5, 1'b1);
      pnl.press(0);
      tk(2);
      chk("ack_while_high", active_o[5], 1'b1);
      fire(5, 1'b0);
      see(1'b1, 5);
      pnl.press(0);
      tk(2);
      chk("ack_done", active_o[5], 1'b0);
      // Leaving run mode hides the message but keeps it set; rises are lost
      fire(11, 1'b1);
      @(posedge clk_i);
      run_mode_i <= 1'b0;
      fire(3, 1'b1);
      see(1'b0, 0);
      chk("run_off", active_o[3], 1'b0);
      chk("kept_set", active_o[11], 1'b1);
      @(posedge clk_i);
      run_mode_i <= 1'b1;
      tk(4);
      chk("no_late_rise", active_o[3], 1'b0);
      see(1'b1, 11);
      fire(3, 1'b0);
      fire(11, 1'b0);
      // Glyph table selection by flag
      fire(7, 1'b1);
      see(1'b0, 0);
      @(posedge clk_i);
      charset_select_flag_i <= 1'b1;
      tk(3);
      see(1'b1, 7);
      @(posedge clk_i);
      charset_select_flag_i <= 1'b0;
      fire(7, 1'b0);
      // Keys step between set messages, wrapping
      fire(3, 1'b1);
      fire(11, 1'b1);
      pnl.press(2);
      tk(2);
      see(1'b1, 3);
      pnl.press(1);
      tk(2);
      see(1'b1, 11);
      pnl.press(1);
      tk(2);
      see(1'b1, 3);
      fire(3, 1'b0);
      fire(11, 1'b0);
      // Scroll by character at 1 ms, by line at ten times that
      fire(20, 1'b1);
      wait_pos(5'h01, 12);
      fire(20, 1'b0);
      fire(21, 1'b1);
      tk(28);
      chk("line_early", scroll_pos_o, POS_RESET);
      wait_pos(HALF_CHARS, 20);
      fire(21, 1'b0);
      // Analog refresh spacing, 2 ms counted in clock cycles
      wait_pulse(k);
      tk(1);
      wait_pulse(k);
      chk("analog_gap", k, 2 * MSC);
      final_report();
   end
endmodule
`default_nettype wire

/* File: tb/op_panel_model.sv */
// Operator key panel model feeding the message selector
`timescale 1ns/10ps
`default_nettype none
module op_panel_model (
   // Clock
   input wire logic clk_i,
   // Keys, high for one cycle
   output logic confirm_key_o,
   output logic key_up_o,
   output logic key_down_o
);
   // Keys rest released
   initial begin
      confirm_key_o = 1'b0;
      key_up_o = 1'b0;
      key_down_o = 1'b0;
   end
   // One press: 0 confirm, 1 up, 2 down; never held, so no repeat
   task automatic press(input int k);
      @(posedge clk_i);
      confirm_key_o <= (k == 0);
      key_up_o <= (k == 1);
      key_down_o <= (k == 2);
      @(posedge clk_i);
      confirm_key_o <= 1'b0;
      key_up_o <= 1'b0;
      key_down_o <= 1'b0;
   endtask
endmodule
`default_nettype wire
